/* File: core/sml_coil_meas.sv */
`timescale 1ns/1ps
module sml_coil_meas #(
  parameter int unsigned CNT_W = 16,
  parameter int unsigned TICK_CYCLES = 200
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // control
  input wire logic start_i,
  input wire logic enh_i,
  // winding feedback
  input wire logic hold_on_i,
  input wire logic cur_reached_i,
  input wire logic amp_step_i,
  // result
  output logic [CNT_W-1:0] result_o,
  output logic busy_o,
  output logic done_o,
  output logic valid_o
);
  localparam int unsigned TW = $clog2(TICK_CYCLES + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
  sml_pkg::sml_meas_state_type state_q;
  logic armed_q;
  logic hold_prev_q;
  logic [CNT_W-1:0] cnt_q;
  logic [TW-1:0] tick_q;
  logic go;
  logic cnt_max;
  logic finish;

  // first holding-current application after reset measures on its own
  assign go = start_i | (armed_q & hold_on_i & ~hold_prev_q); // see [R13]
  assign cnt_max = &cnt_q;
  assign finish = hold_on_i & (((state_q == sml_pkg::SML_NORM) & cur_reached_i) |
                               ((state_q == sml_pkg::SML_ENH) & amp_step_i));
  assign busy_o = (state_q != sml_pkg::SML_IDLE);

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hold_prev_q <= 1'b0;
      armed_q <= 1'b1;
    end else begin
      hold_prev_q <= hold_on_i;
      if (go && state_q == sml_pkg::SML_IDLE) begin
        armed_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= sml_pkg::SML_IDLE;
      cnt_q <= '0;
      tick_q <= '0;
    end else begin
      case (state_q)
        sml_pkg::SML_IDLE: begin
          if (go) begin
            state_q <= enh_i ? sml_pkg::SML_ENH : sml_pkg::SML_NORM; // see [R9]
            cnt_q <= '0;
            tick_q <= '0;
          end
        end
        sml_pkg::SML_NORM: begin
          // counts clock cycles of current application
          if (!hold_on_i || cur_reached_i) begin
            state_q <= sml_pkg::SML_IDLE;
          end else if (!cnt_max) begin
            cnt_q <= cnt_q + CNT_W'(1); // see [R10]
          end
        end
        sml_pkg::SML_ENH: begin
          if (!hold_on_i || amp_step_i) begin
            state_q <= sml_pkg::SML_IDLE;
          end else if (tick_q == TICK_LAST) begin
            tick_q <= '0;
            if (!cnt_max) begin
              cnt_q <= cnt_q + CNT_W'(1); // see [R11]
            end
          end else begin
            tick_q <= tick_q + TW'(1);
          end
        end
        default: state_q <= sml_pkg::SML_IDLE;
      endcase
    end
  end

  // an aborted run (holding current dropped) leaves the old result
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      result_o <= '0;
      done_o <= 1'b0;
      valid_o <= 1'b0;
    end else begin
      done_o <= finish;
      if (finish) begin
        result_o <= cnt_q; // see [R15]
        valid_o <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  result_hold_a: assert property ($changed(result_o) |-> done_o) // see [R15]
    else $error("result changed without a completed measurement");
  mode_enh_a: assert property (state_q == sml_pkg::SML_IDLE && start_i && enh_i // see [R9]
    |=> state_q == sml_pkg::SML_ENH)
    else $error("enhanced mode not entered");
  norm_result_a: assert property (state_q == sml_pkg::SML_NORM && hold_on_i // see [R10]
    && cur_reached_i |=> done_o && result_o == $past(cnt_q))
    else $error("normal result not captured");
  auto_meas_a: assert property (state_q == sml_pkg::SML_IDLE && armed_q // see [R13]
    && hold_on_i && !hold_prev_q |=> busy_o ##0 !armed_q)
    else $error("first holding current did not start measurement");
endmodule

/* File: core/sml_pkg.sv */
package sml_pkg;
  // channel count and register map, byte addresses of aligned words
  localparam int unsigned NCH = 2;
  localparam int unsigned AW = 8;
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_TEMP = 8'h04;
  localparam logic [7:0] OFS_LOAD = 8'h08;
  localparam logic [7:0] OFS_TRIG = 8'h0C;
  localparam logic [7:0] OFS_SIG1 = 8'h10;
  localparam logic [7:0] OFS_SIG2 = 8'h14;
  localparam logic [7:0] OFS_POS1 = 8'h18;
  localparam logic [7:0] OFS_POS2 = 8'h1C;
  localparam logic [7:0] OFS_ENC1 = 8'h20;
  localparam logic [7:0] OFS_ENC2 = 8'h24;
  localparam logic [7:0] OFS_STATUS = 8'h28;
  // field layout
  localparam int unsigned CFG_ENH_BIT = 11;
  localparam logic CFG_ENH_RESET = 1'b0;
  localparam int unsigned TEMP_W = 8;
  localparam int unsigned LOAD_W = 3;
  localparam int unsigned LOAD_CH2_LSB = 4;
  localparam int unsigned TRIG_W = 2;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned STAT_VALID_LSB = 4;
  // position counter in 1/256 full-step units; reset value is a half-step spot
  localparam logic [15:0] POS_RESET = 16'h0000;
  localparam logic [15:0] ENC_RESET = 16'h0000;
  localparam logic [15:0] STEP_COARSE = 16'h0004;
  localparam logic [15:0] STEP_FINE = 16'h0001;
  localparam logic [15:0] MASK_COARSE = 16'hFFFC;
  localparam logic [15:0] MASK_FINE = 16'hFFFF;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  // timing: enhanced result counts microseconds
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned MEAS_TICK_US = 1;
  localparam int unsigned TICK_CYCLES = MEAS_TICK_US * CLK_MHZ;
  typedef enum logic [1:0] {SML_IDLE, SML_NORM, SML_ENH} sml_meas_state_type;
endpackage

/* File: core/sml_status.sv */
// Summary of operation
// [R1] outside enhanced mode position resolves 1/64 step; two lowest bits read zero
// [R2] each channel keeps a 16-bit quadrature encoder counter that wraps both ways
// [R3] position setpoint is a 16-bit cyclic counter, microsteps low, full steps high
// [R4] module temperature reads as signed 8-bit degrees, -128 to 127
// [R5] latest load per motor, 3 bits: motor one bits 0-2, two bits 4-6
// [R6] load bits 3 and 7 and trigger bits 2-7 read zero, writes ignored
// [R7] rising edge of trigger bit 0 or 1 starts measurement for that motor
// [R8] software ensures identification conditions hold before raising a trigger edge
// [R9] configuration bit 11 selects normal (0) or enhanced (1) result meaning
// [R10] normal result tells how long current was applied to the windings
// [R11] enhanced result is microseconds for a 1 A current rise, after success
// [R12] software runs holding current, standstill, half-step position for normal mode
// [R13] reset starts at half-step standstill; first holding current is measured
// [R14] software should read the result right after that first measurement
// [R15] each result keeps its value until a new measurement of it completes
`timescale 1ns/1ps
module sml_status #(
  parameter int unsigned NCH = sml_pkg::NCH,
  parameter int unsigned TICK_CYCLES = sml_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [sml_pkg::AW-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // motor sensing
  input wire logic signed [sml_pkg::TEMP_W-1:0] temp_i,
  input wire logic [NCH*sml_pkg::LOAD_W-1:0] stall_load_i,
  // step generator, one pulse per step: 1/256 step in enhanced mode, 1/64 step in normal mode
  input wire logic [NCH-1:0] step_i,
  input wire logic [NCH-1:0] dir_i,
  // encoders
  input wire logic [NCH-1:0] enc_a_i,
  input wire logic [NCH-1:0] enc_b_i,
  // winding feedback
  input wire logic [NCH-1:0] hold_on_i,
  input wire logic [NCH-1:0] cur_reached_i,
  input wire logic [NCH-1:0] amp_step_i,
  // status
  output logic [NCH-1:0] meas_busy_o,
  output logic enh_mode_o
);
  localparam int unsigned LW = sml_pkg::LOAD_W;

  logic cfg_enh_q;
  logic signed [sml_pkg::TEMP_W-1:0] temp_q;
  logic [LW-1:0] load_q [NCH];
  logic [sml_pkg::TRIG_W-1:0] trig_q;
  logic [sml_pkg::TRIG_W-1:0] start_q;
  logic [15:0] pos_q [NCH];
  logic [15:0] enc_q [NCH];
  logic [NCH-1:0] qa_q;
  logic [NCH-1:0] qb_q;
  logic [NCH-1:0] enc_en;
  logic [NCH-1:0] enc_up;
  logic [sml_pkg::CNT_W-1:0] sig [NCH];
  logic [NCH-1:0] meas_done;
  logic [NCH-1:0] meas_valid;
  logic [15:0] step_inc;
  logic [15:0] step_mask;
  logic [7:0] load_word;
  logic [31:0] rd_d;
  logic err_d;
  logic setup;
  logic access;
  logic wr_ok;
  logic [31:0] prdata_q;
  logic pslverr_q;

  assign setup = psel_i & ~penable_i;
  assign access = psel_i & penable_i;
  // zero wait states; read data was captured in the setup cycle
  assign pready_o = 1'b1;
  assign prdata_o = prdata_q;
  assign pslverr_o = pslverr_q;
  assign wr_ok = access & pwrite_i & ~err_d;
  assign enh_mode_o = cfg_enh_q;
  assign step_inc = cfg_enh_q ? sml_pkg::STEP_FINE : sml_pkg::STEP_COARSE; // see [R1]
  assign step_mask = cfg_enh_q ? sml_pkg::MASK_FINE : sml_pkg::MASK_COARSE; // see [R1]
  assign load_word = {1'b0, load_q[1], 1'b0, load_q[0]}; // see [R5] see [R6]

  // configuration word, only the mode bit is stored
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_enh_q <= sml_pkg::CFG_ENH_RESET;
    end else if (wr_ok && paddr_i == sml_pkg::OFS_CONFIG) begin
      cfg_enh_q <= pwdata_i[sml_pkg::CFG_ENH_BIT]; // see [R9]
    end
  end

  // trigger register: edge detect against the last written value
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      trig_q <= '0;
      start_q <= '0;
    end else begin
      start_q <= '0;
      if (wr_ok && paddr_i == sml_pkg::OFS_TRIG) begin
        trig_q <= pwdata_i[sml_pkg::TRIG_W-1:0]; // see [R6]
        start_q <= pwdata_i[sml_pkg::TRIG_W-1:0] & ~trig_q; // see [R7]
      end
    end
  end

  // sensor values refresh every cycle so reads show the latest figure
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      temp_q <= '0;
    end else begin
      temp_q <= temp_i; // see [R4]
    end
  end

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        load_q[c] <= '0;
      end else begin
        load_q[c] <= stall_load_i[c*LW +: LW]; // see [R5]
      end
    end

    // x4 decode: one count per edge on either line
    assign enc_en[c] = enc_a_i[c] ^ qa_q[c] ^ enc_b_i[c] ^ qb_q[c];
    assign enc_up[c] = enc_a_i[c] ^ qb_q[c];

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        qa_q[c] <= 1'b0;
        qb_q[c] <= 1'b0;
        enc_q[c] <= sml_pkg::ENC_RESET;
      end else begin
        qa_q[c] <= enc_a_i[c];
        qb_q[c] <= enc_b_i[c];
        if (enc_en[c]) begin
          enc_q[c] <= enc_up[c] ? enc_q[c] + sml_pkg::CNT_ONE // see [R2]
                                : enc_q[c] - sml_pkg::CNT_ONE;
        end
      end
    end

    // masking every cycle also clears fine bits left from enhanced mode
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        pos_q[c] <= sml_pkg::POS_RESET; // see [R13]
      end else if (step_i[c]) begin
        pos_q[c] <= (dir_i[c] ? pos_q[c] + step_inc : pos_q[c] - step_inc) // see [R3]
                    & step_mask;
      end else begin
        pos_q[c] <= pos_q[c] & step_mask; // see [R1]
      end
    end

    sml_coil_meas #(
      .CNT_W(sml_pkg::CNT_W),
      .TICK_CYCLES(TICK_CYCLES)
    ) u_meas (
      .core_clk_i(core_clk_i),
      .nrst_i(nrst_i),
      .start_i(start_q[c]),
      .enh_i(cfg_enh_q),
      .hold_on_i(hold_on_i[c]),
      .cur_reached_i(cur_reached_i[c]),
      .amp_step_i(amp_step_i[c]),
      .result_o(sig[c]),
      .busy_o(meas_busy_o[c]),
      .done_o(meas_done[c]),
      .valid_o(meas_valid[c])
    );
  end

  // read decode; unmapped addresses answer with an error
  always_comb begin
    rd_d = '0;
    err_d = 1'b0;
    case (paddr_i)
      sml_pkg::OFS_CONFIG: begin
        rd_d[sml_pkg::CFG_ENH_BIT] = cfg_enh_q;
      end
      sml_pkg::OFS_TEMP: begin
        rd_d[sml_pkg::TEMP_W-1:0] = temp_q; // see [R4]
      end
      sml_pkg::OFS_LOAD: begin
        rd_d[7:0] = load_word; // see [R6]
      end
      sml_pkg::OFS_TRIG: begin
        rd_d = '0; // see [R6]
      end
      sml_pkg::OFS_SIG1: begin
        rd_d[sml_pkg::CNT_W-1:0] = sig[0];
      end
      sml_pkg::OFS_SIG2: begin
        rd_d[sml_pkg::CNT_W-1:0] = sig[1];
      end
      sml_pkg::OFS_POS1: begin
        rd_d[15:0] = pos_q[0];
      end
      sml_pkg::OFS_POS2: begin
        rd_d[15:0] = pos_q[1];
      end
      sml_pkg::OFS_ENC1: begin
        rd_d[15:0] = enc_q[0];
      end
      sml_pkg::OFS_ENC2: begin
        rd_d[15:0] = enc_q[1];
      end
      sml_pkg::OFS_STATUS: begin
        rd_d[NCH-1:0] = meas_busy_o;
        rd_d[sml_pkg::STAT_VALID_LSB +: NCH] = meas_valid;
      end
      default: begin
        err_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prdata_q <= '0;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= pwrite_i ? '0 : rd_d;
      pslverr_q <= err_d;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  sequence trig_rise0_s;
    access && pwrite_i && paddr_i == sml_pkg::OFS_TRIG && pwdata_i[0] && !trig_q[0];
  endsequence
  sequence one_start0_s;
    start_q[0] ##1 !start_q[0];
  endsequence

  pos_fine_a: assert property ((!cfg_enh_q)[*2] |-> pos_q[0][1:0] == 2'b00 // see [R1]
    && pos_q[1][1:0] == 2'b00)
    else $error("fine position bits set in normal mode");
  enc_wrap_a: assert property (enc_en[0] && enc_up[0] && enc_q[0] == 16'hFFFF // see [R2]
    |=> enc_q[0] == 16'h0000)
    else $error("encoder counter did not wrap");
  enc_under_a: assert property (enc_en[1] && !enc_up[1] && enc_q[1] == 16'h0000 // see [R2]
    |=> enc_q[1] == 16'hFFFF)
    else $error("encoder counter did not wrap down");
  pos_step_a: assert property (step_i[0] && dir_i[0] && cfg_enh_q // see [R3]
    |=> pos_q[0] == 16'($past(pos_q[0]) + sml_pkg::STEP_FINE))
    else $error("position step not applied");
  temp_read_a: assert property (setup && !pwrite_i && paddr_i == sml_pkg::OFS_TEMP // see [R4]
    |=> prdata_o == {24'h000000, $past(temp_q)})
    else $error("temperature read mismatch");
  load_map_a: assert property (1'b1 |=> load_word == {1'b0, $past(stall_load_i[5:3]), // see [R5]
    1'b0, $past(stall_load_i[2:0])})
    else $error("load fields misplaced");
  rsvd_zero_a: assert property (setup && (paddr_i == sml_pkg::OFS_LOAD // see [R6]
    || paddr_i == sml_pkg::OFS_TRIG) |=> prdata_o[3] == 1'b0 && prdata_o[31:7] == 25'h0
    && (prdata_o[2:0] == 3'h0 || $past(paddr_i) == sml_pkg::OFS_LOAD))
    else $error("reserved bits not zero");
  trig_edge_a: assert property (trig_rise0_s |=> one_start0_s) // see [R7]
    else $error("trigger edge did not start one measurement");
  trig_level_a: assert property (access && pwrite_i && paddr_i == sml_pkg::OFS_TRIG // see [R7]
    && trig_q[1] |=> !start_q[1])
    else $error("steady trigger level started a measurement");
  slverr_a: assert property (setup && err_d |=> pslverr_o && pready_o)
    else $error("unmapped address not refused");
endmodule

/* File: tb/sml_motor_model.sv */
`timescale 1ns/1ps
// far side: two windings whose current ramps up, and two quadrature encoders
module sml_motor_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // bench control
  input wire logic [1:0] hold_req_i,
  input wire logic [15:0] rise_cyc_i,
  input wire logic [1:0] enc_up_i,
  input wire logic [1:0] enc_dn_i,
  // device side
  input wire logic [1:0] meas_busy_i,
  output logic [1:0] hold_on_o,
  output logic [1:0] cur_reached_o,
  output logic [1:0] amp_step_o,
  output logic [1:0] enc_a_o,
  output logic [1:0] enc_b_o
);
  logic [15:0] ramp_q [2];
  logic [1:0] ph_q [2];
  logic [1:0] busy_q;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hold_on_o <= 2'h0;
      busy_q <= 2'h0;
      for (int c = 0; c < 2; c++) begin
        ramp_q[c] <= 16'h0000;
        ph_q[c] <= 2'h0;
      end
    end else begin
      busy_q <= meas_busy_i;
      for (int c = 0; c < 2; c++) begin
        // holding current follows the bench request one cycle later
        hold_on_o[c] <= hold_req_i[c];
        // a new run re-energises the winding from zero, so old current cannot end it
        if (!hold_on_o[c] || (meas_busy_i[c] && !busy_q[c])) begin
          ramp_q[c] <= 16'h0000;
        end else if (ramp_q[c] != 16'hFFFF) begin
          ramp_q[c] <= ramp_q[c] + 16'h0001;
        end
        ph_q[c] <= ph_q[c] + {1'b0, enc_up_i[c]} - {1'b0, enc_dn_i[c]};
      end
    end
  end
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      cur_reached_o[c] = hold_on_o[c] && ramp_q[c] >= rise_cyc_i
        && !(meas_busy_i[c] && !busy_q[c]);
      amp_step_o[c] = cur_reached_o[c];
      enc_a_o[c] = ph_q[c][1] ^ ph_q[c][0];
      enc_b_o[c] = ph_q[c][1];
    end
  end
endmodule

/* File: tb/test_stepper_status_and_motor_ident.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch t=%0t got %h exp %h", $time, (g), (e)); end end
module test_stepper_status_and_motor_ident;
  logic core_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o, rd;
  logic pready_o, pslverr_o, enh_mode_o, err;
  logic signed [7:0] temp_i = 8'sh00;
  logic [5:0] stall_load_i = 6'h00;
  logic [1:0] step_i = 2'h0;
  logic [1:0] dir_i = 2'h0;
  logic [1:0] enc_a_i, enc_b_i, hold_on_i, cur_reached_i, amp_step_i, meas_busy_o, u;
  logic [1:0] hold_req = 2'h0;
  logic [1:0] enc_up = 2'h0;
  logic [1:0] enc_dn = 2'h0;
  logic [15:0] rise_cyc = 16'h0028;
  logic [7:0] t;
  int num_errors = 0;
  int tests_run = 0;
  int pos [2] = '{0, 0};
  int enc [2] = '{0, 0};
  int unit;
  sml_status #(.NCH(2), .TICK_CYCLES(4)) dut_u (.core_clk_i, .nrst_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .temp_i, .stall_load_i,
    .step_i, .dir_i, .enc_a_i, .enc_b_i, .hold_on_i, .cur_reached_i, .amp_step_i,
    .meas_busy_o, .enh_mode_o);
  sml_motor_model mot_u (.clk_i(core_clk_i), .nrst_i(nrst_i), .hold_req_i(hold_req),
    .rise_cyc_i(rise_cyc), .enc_up_i(enc_up), .enc_dn_i(enc_dn), .meas_busy_i(meas_busy_o),
    .hold_on_o(hold_on_i), .cur_reached_o(cur_reached_i), .amp_step_o(amp_step_i),
    .enc_a_o(enc_a_i), .enc_b_o(enc_b_i));
  initial begin
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  task automatic give_verdict();
    if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      give_verdict();
    end
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  // result of channel c must fall between lo and hi
  task automatic sig_chk(input int c, input int lo, input int hi);
    apb(1'b0, c ? sml_pkg::OFS_SIG2 : sml_pkg::OFS_SIG1, 32'h0);
    `CHK(rd[15:0] >= lo && rd[15:0] <= hi, 1'b1)
  endtask
  // c of 2 waits for both channels, which start together on the automatic run
  task automatic meas_wait(input int c);
    int n;
    logic [1:0] m;
    m = (c == 2) ? 2'b11 : (2'b01 << c);
    for (n = 0; n < 20 && (meas_busy_o & m) !== m; n++) @(posedge core_clk_i);
    `CHK(meas_busy_o & m, m)
    for (n = 0; n < 3000 && (meas_busy_o & m) !== 2'b00; n++) @(posedge core_clk_i);
    `CHK(meas_busy_o & m, 2'b00)
  endtask
  initial begin
    repeat (100000) @(posedge core_clk_i);
    num_errors++;
    give_verdict();
  end
  initial begin
    void'($urandom(32'h327ef1d1));
    repeat (5) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    @(posedge core_clk_i);
    rd_chk(sml_pkg::OFS_CONFIG, 32'h0);
    hold_req <= 2'b11;
    meas_wait(2);
    `CHK(meas_busy_o, 2'b00)
    sig_chk(0, 38, 44);
    sig_chk(1, 38, 44);
    rd_chk(sml_pkg::OFS_STATUS, 32'h30);
    rise_cyc <= 16'h003C;
    apb(1'b1, sml_pkg::OFS_TRIG, 32'h1);
    meas_wait(0);
    sig_chk(0, 58, 64);
    sig_chk(1, 38, 44);
    // a steady one is not an edge
    apb(1'b1, sml_pkg::OFS_TRIG, 32'h1);
    repeat (4) @(posedge core_clk_i);
    `CHK(meas_busy_o, 2'b00)
    rise_cyc <= 16'h001E;
    apb(1'b1, sml_pkg::OFS_TRIG, 32'h2);
    meas_wait(1);
    sig_chk(1, 28, 34);
    sig_chk(0, 58, 64);
    apb(1'b1, sml_pkg::OFS_CONFIG, 32'h800);
    `CHK(enh_mode_o, 1'b1)
    rd_chk(sml_pkg::OFS_CONFIG, 32'h800);
    rise_cyc <= 16'h0028;
    apb(1'b1, sml_pkg::OFS_TRIG, 32'h1);
    meas_wait(0);
    sig_chk(0, 9, 12);
    // abort by dropping holding current keeps the old result
    apb(1'b1, sml_pkg::OFS_TRIG, 32'h2);
    repeat (4) @(posedge core_clk_i);
    hold_req <= 2'b01;
    meas_wait(1);
    sig_chk(1, 28, 34);
    hold_req <= 2'b11;
    // position: enhanced pass moves 1, normal pass 4 with low bits cleared
    for (int m = 0; m < 2; m++) begin
      unit = m ? 4 : 1;
      if (m) begin
        apb(1'b1, sml_pkg::OFS_CONFIG, 32'h0);
        for (int c = 0; c < 2; c++) pos[c] = pos[c] & 32'hFFFC;
      end
      for (int i = 0; i < 10; i++) begin
        u = $urandom;
        step_i <= 2'b11;
        dir_i <= i ? u : 2'b00;
        @(posedge core_clk_i);
        step_i <= 2'b00;
        @(posedge core_clk_i);
        for (int c = 0; c < 2; c++) pos[c] += (i && u[c]) ? unit : -unit;
      end
      rd_chk(sml_pkg::OFS_POS1, {16'h0, pos[0][15:0]});
      rd_chk(sml_pkg::OFS_POS2, {16'h0, pos[1][15:0]});
    end
    for (int i = 0; i < 16; i++) begin
      u = i ? 2'($urandom) : 2'b00;
      enc_up <= u;
      enc_dn <= ~u;
      @(posedge core_clk_i);
      enc_up <= 2'b00;
      enc_dn <= 2'b00;
      repeat (2) @(posedge core_clk_i);
      for (int c = 0; c < 2; c++) enc[c] += u[c] ? 1 : -1;
    end
    repeat (4) @(posedge core_clk_i);
    rd_chk(sml_pkg::OFS_ENC1, {16'h0, enc[0][15:0]});
    rd_chk(sml_pkg::OFS_ENC2, {16'h0, enc[1][15:0]});
    for (int i = 0; i < 4; i++) begin
      t = (i == 0) ? 8'h80 : (i == 1) ? 8'h7F : 8'($urandom);
      u = $urandom;
      temp_i <= t;
      stall_load_i <= 6'($urandom);
      repeat (3) @(posedge core_clk_i);
      rd_chk(sml_pkg::OFS_TEMP, {24'h0, t});
      rd_chk(sml_pkg::OFS_LOAD, {25'h0, stall_load_i[5:3], 1'b0, stall_load_i[2:0]});
    end
    apb(1'b1, sml_pkg::OFS_LOAD, 32'hFF);
    rd_chk(sml_pkg::OFS_LOAD, {25'h0, stall_load_i[5:3], 1'b0, stall_load_i[2:0]});
    rd_chk(sml_pkg::OFS_TRIG, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    `CHK(err, 1'b1)
    give_verdict();
  end
endmodule
